// >>> common/xcv_pkg.sv
// constants and types shared by the transceiver register bank
`default_nettype none
package xcv_pkg;
  // register numbers within the alternate bank
  localparam logic [2:0] IDX_FIFO_PORT = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  localparam logic [2:0] IDX_COMMAND = 3'h6;
  localparam logic [2:0] IDX_MODE = 3'h7;
  // mode register fields
  localparam int MODE_RESET_BIT = 7;
  localparam int MODE_LOOP_BIT = 6;
  localparam int MODE_CONC_RX_BIT = 5;
  localparam int MODE_RX_INV_BIT = 4;
  localparam int MODE_TX_INV_BIT = 3;
  localparam logic [7:0] MODE_RESET_VAL = 8'h00;
  // command register fields
  localparam int CMD_SEL_ERR_BIT = 6;
  localparam int CMD_PARITY_BIT = 3;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;
  // status register fields
  localparam int STAT_TX_FULL_BIT = 7;
  localparam int STAT_TX_ACTIVE_OUTPUT_BIT = 6;
  localparam int STAT_RX_ERR_BIT = 5;
  localparam int STAT_RX_ACT_BIT = 4;
  localparam int STAT_DAV_BIT = 3;
  // error code bits; the receiver supplies all but the disable bit
  localparam int ERR_RX_DISABLED_BIT = 0;
  localparam int ERR_WIDTH = 5;
  // protocol codes with two-byte address framing
  localparam logic [2:0] PROTO_TWO_BYTE = 3'h4;
  localparam logic [2:0] PROTO_TWO_BYTE_PROM = 3'h5;
  // quiet transceiver clock periods before line activity drops
  localparam int LA_IDLE_TCLKS = 16;
  localparam logic [4:0] LA_LAST_COUNT = 5'(LA_IDLE_TCLKS - 1);
  localparam int RX_FIFO_DEPTH = 3;
  localparam int TX_FIFO_DEPTH = 2;

  typedef struct packed {
    logic parity_odd;
    logic [10:0] word;
  } xcv_tx_word_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic [ERR_WIDTH-1:1] err;
  } xcv_rx_event_type;
endpackage : xcv_pkg
`default_nettype wire

// >>> core/xcv_regs.sv
// transceiver mode and status registers, data port fifos and line glue
//
// Contract
// - writing the data port pushes parity select, three high bits and byte
// - reset bit holds transceiver in reset; system reset leaves the bit alone
// - wraparound forces active output low and loops serial data inward
// - without concurrent enable, transmitting stops an active receiver
// - receive invert flips incoming serial data before decoding
// - transmit invert flips all transmitter serial outputs
// - three-bit protocol select configures transmitter and receiver together
// - transmit fifo full flag is set whenever no entry is free, except while the transceiver is held in reset
// - transmitter active flag follows transmitter, ignoring the wraparound force
// - error flag sets on any error, clears on error code read or reset bit
// - receiver active sets on start, clears on end, error, or activity loss in two-byte framing
// - data available sets with readable word, clears on read or error
// - status low three bits and port byte present the receive fifo head
// - reading the data port pops the receive fifo head word
// - line activity sets on transitions, clears after sixteen quiet periods
`default_nettype none

module xcv_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count_q != FULL_COUNT) && !flush_i;
  assign out_valid_o = (count_q != '0) && !flush_i;
  assign out_data_o = mem_q[rd_ptr_q];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (flush_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) mem_q[e] <= '0;
      else if (flush_i) mem_q[e] <= '0;
      else if (push && wr_ptr_q == PW'(e)) mem_q[e] <= in_data_i;
    end
  end
endmodule : xcv_fifo

module xcv_regs
  import xcv_pkg::*;
#(
  parameter int RX_DEPTH = RX_FIFO_DEPTH,
  parameter int TX_DEPTH = TX_FIFO_DEPTH
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic PWR_RESETN_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic TRANSCEIVER_CLOCK_EN_I,
  output xcv_tx_word_type TX_WORD_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic TX_ACTIVE_I,
  input wire logic TX_SERIAL_I,
  output logic TX_DATA_O,
  output logic TX_DATA_N_O,
  output logic TX_ACTIVE_OUTPUT_O,
  input wire logic RX_PIN_I,
  output logic RX_SERIAL_O,
  input wire logic [10:0] RX_WORD_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  input wire xcv_rx_event_type RX_EVENT_I,
  output logic RX_ABORT_O,
  output logic XCVR_RESET_O,
  output logic [2:0] PROTOCOL_O,
  output logic LINE_ACTIVE_O
);
  logic [7:0] mode_q;
  logic [7:0] cmd_q;
  logic xcvr_rst_q;
  logic rx_sync1_q;
  logic rx_sync2_q;
  logic rx_prev_q;
  logic la_q;
  logic [4:0] la_cnt_q;
  logic tx_active_output_in_q;
  logic [ERR_WIDTH-1:0] ecr_q;
  logic rx_active_q;
  logic dav_hide_q;
  logic [7:0] rdata_q;
  logic tx_data_q;
  logic tx_active_output_q;
  logic abort_q;

  // register decode
  wire hit_port = REG_ADDR_I == IDX_FIFO_PORT;
  wire sel_err = cmd_q[CMD_SEL_ERR_BIT];
  wire wr_port = REG_WR_I && hit_port;
  wire rd_port = REG_RD_I && hit_port && !sel_err;
  wire rd_ecr = REG_RD_I && hit_port && sel_err;
  wire wr_mode = REG_WR_I && (REG_ADDR_I == IDX_MODE);
  wire wr_cmd = REG_WR_I && (REG_ADDR_I == IDX_COMMAND);

  wire loop_en = mode_q[MODE_LOOP_BIT];
  wire conc_rx = mode_q[MODE_CONC_RX_BIT];
  wire rx_inv = mode_q[MODE_RX_INV_BIT];
  wire tx_inv = mode_q[MODE_TX_INV_BIT];
  wire [2:0] proto = mode_q[2:0];
  wire two_byte_mode = (proto == PROTO_TWO_BYTE) || (proto == PROTO_TWO_BYTE_PROM);

  // fifos
  xcv_tx_word_type tx_push_word;
  xcv_tx_word_type tx_head;
  logic tx_in_ready;
  logic rx_out_valid;
  logic [10:0] rx_head;
  wire tx_full = !tx_in_ready && !xcvr_rst_q;

  assign tx_push_word = '{parity_odd: cmd_q[CMD_PARITY_BIT],
                          word: {cmd_q[2:0], REG_WDATA_I}};

  xcv_fifo #(.WIDTH(12), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .flush_i(xcvr_rst_q),
    .in_valid_i(wr_port),
    .in_ready_o(tx_in_ready),
    .in_data_i(tx_push_word),
    .out_valid_o(TX_VALID_O),
    .out_ready_i(TX_READY_I),
    .out_data_o(tx_head)
  );
  assign TX_WORD_O = tx_head;

  xcv_fifo #(.WIDTH(11), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .flush_i(xcvr_rst_q),
    .in_valid_i(RX_VALID_I),
    .in_ready_o(RX_READY_O),
    .in_data_i(RX_WORD_I),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rd_port),
    .out_data_o(rx_head)
  );

  // mode register survives system reset; only power-on clears it
  always_ff @(posedge CLOCK_I or negedge PWR_RESETN_I) begin
    if (!PWR_RESETN_I) mode_q <= MODE_RESET_VAL;
    else if (wr_mode) mode_q <= REG_WDATA_I;
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) cmd_q <= CMD_RESET_VAL;
    else if (wr_cmd) cmd_q <= REG_WDATA_I;
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) xcvr_rst_q <= 1'b1;
    else xcvr_rst_q <= mode_q[MODE_RESET_BIT];
  end
  assign XCVR_RESET_O = xcvr_rst_q;
  assign PROTOCOL_O = proto;

  // receive line: synchronise, wrap, invert
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_sync1_q <= 1'b0;
      rx_sync2_q <= 1'b0;
    end else begin
      rx_sync1_q <= RX_PIN_I;
      rx_sync2_q <= rx_sync1_q;
    end
  end
  wire rx_line = loop_en ? TX_SERIAL_I : rx_sync2_q;
  wire rx_serial = rx_line ^ rx_inv;
  assign RX_SERIAL_O = rx_serial;

  // line activity over the transceiver clock enable
  wire rx_edge = rx_serial != rx_prev_q;
  wire la_expire = la_q && TRANSCEIVER_CLOCK_EN_I && !rx_edge && (la_cnt_q == LA_LAST_COUNT);
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_prev_q <= 1'b0;
      la_q <= 1'b0;
      la_cnt_q <= '0;
    end else if (xcvr_rst_q) begin
      rx_prev_q <= rx_serial;
      la_q <= 1'b0;
      la_cnt_q <= '0;
    end else begin
      rx_prev_q <= rx_serial;
      if (rx_edge) begin
        la_q <= 1'b1;
        la_cnt_q <= '0;
      end else if (la_expire) begin
        la_q <= 1'b0;
      end else if (la_q && TRANSCEIVER_CLOCK_EN_I) begin
        la_cnt_q <= la_cnt_q + 5'h01;
      end
    end
  end
  assign LINE_ACTIVE_O = la_q;

  // transmitter activity and the receiver disable it may cause
  wire tx_starts = TX_ACTIVE_I && !tx_active_output_in_q;
  wire rx_disable = tx_starts && rx_active_q && !conc_rx;
  wire [ERR_WIDTH-1:0] err_now = {RX_EVENT_I.err, rx_disable};
  wire any_err = |err_now;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_active_output_in_q <= 1'b0;
      tx_active_output_q <= 1'b0;
      tx_data_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      tx_active_output_in_q <= TX_ACTIVE_I;
      tx_active_output_q <= TX_ACTIVE_I && !loop_en;
      tx_data_q <= TX_SERIAL_I ^ tx_inv;
      abort_q <= rx_disable;
    end
  end
  assign TX_ACTIVE_OUTPUT_O = tx_active_output_q;
  assign TX_DATA_O = tx_data_q;
  assign TX_DATA_N_O = !tx_data_q;
  assign RX_ABORT_O = abort_q;

  // error codes: a new error wins over the clearing read
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) ecr_q <= '0;
    else if (xcvr_rst_q) ecr_q <= '0;
    else ecr_q <= (rd_ecr ? '0 : ecr_q) | err_now;
  end
  wire rx_err_flag = |ecr_q;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) rx_active_q <= 1'b0;
    else if (xcvr_rst_q) rx_active_q <= 1'b0;
    else if (RX_EVENT_I.start) rx_active_q <= 1'b1;
    else if (RX_EVENT_I.stop || any_err || (two_byte_mode && la_expire))
      rx_active_q <= 1'b0;
  end

  // an error hides the fifo head until a fresh word arrives
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) dav_hide_q <= 1'b0;
    else if (xcvr_rst_q) dav_hide_q <= 1'b0;
    else if (any_err) dav_hide_q <= 1'b1;
    else if (RX_VALID_I && RX_READY_O) dav_hide_q <= 1'b0;
  end
  wire rx_data_valid = rx_out_valid && !dav_hide_q;

  // read side
  wire [7:0] status_val = {tx_full, tx_active_output_in_q, rx_err_flag, rx_active_q, rx_data_valid,
                           rx_head[10:8]};
  wire [7:0] port_val = sel_err ? {3'h0, ecr_q} : rx_head[7:0];
  wire [7:0] rd_val = (REG_ADDR_I == IDX_FIFO_PORT) ? port_val :
                      (REG_ADDR_I == IDX_STATUS) ? status_val :
                      (REG_ADDR_I == IDX_COMMAND) ? cmd_q :
                      (REG_ADDR_I == IDX_MODE) ? mode_q : 8'h00;
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) rdata_q <= 8'h00;
    else if (REG_RD_I) rdata_q <= rd_val;
  end
  assign REG_RDATA_O = rdata_q;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_quiet_edge;
    la_q && TRANSCEIVER_CLOCK_EN_I && !rx_edge && la_cnt_q == LA_LAST_COUNT && !xcvr_rst_q;
  endsequence

  a_tx_push_word: assert property (
    wr_port && !TX_VALID_O && tx_in_ready && !mode_q[MODE_RESET_BIT]
      |=> TX_VALID_O && TX_WORD_O == $past(tx_push_word))
    else $error("written word not at transmit fifo head");
  a_reset_bit_hold: assert property (
    mode_q[MODE_RESET_BIT] |=> XCVR_RESET_O && !TX_VALID_O && !rx_out_valid)
    else $error("reset bit did not hold transceiver reset");
  a_loop_act_low: assert property (
    loop_en && $past(loop_en) |-> !TX_ACTIVE_OUTPUT_O)
    else $error("active output not forced low in wraparound");
  a_rx_disable: assert property (
    rx_disable && !xcvr_rst_q |=> !rx_active_q && RX_ABORT_O && ecr_q[ERR_RX_DISABLED_BIT])
    else $error("receiver not stopped by transmitter start");
  a_tx_full_flag: assert property (
    !xcvr_rst_q |-> status_val[STAT_TX_FULL_BIT] == (u_tx_fifo.count_q == TX_DEPTH))
    else $error("full flag disagrees with fifo");
  a_ta_follows: assert property (
    ##1 status_val[STAT_TX_ACTIVE_OUTPUT_BIT] == $past(TX_ACTIVE_I))
    else $error("transmitter active flag lags wrongly");
  a_err_clear: assert property (
    rd_ecr && !any_err && !xcvr_rst_q |=> !status_val[STAT_RX_ERR_BIT])
    else $error("error flag not cleared by code read");
  a_err_set: assert property (
    any_err && !xcvr_rst_q |=> status_val[STAT_RX_ERR_BIT] && !rx_data_valid)
    else $error("error did not set flag and drop data available");
  a_la_expire: assert property (
    s_quiet_edge |=> !la_q)
    else $error("line activity did not drop after quiet periods");
  a_la_set: assert property (
    rx_edge && !xcvr_rst_q |=> la_q && la_cnt_q == 5'h00)
    else $error("transition did not raise line activity");
  a_head_bits: assert property (
    status_val[2:0] == rx_head[10:8] && (sel_err || port_val == rx_head[7:0]))
    else $error("status and port do not show fifo head");
endmodule : xcv_regs
`default_nettype wire

// >>> verif/xcv_far_model.sv
// stand-in for the transmitter and receiver beside the register bank
`default_nettype none
module xcv_far_model
  import xcv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire xcv_tx_word_type tx_word_i,
  output logic tx_ready_o,
  output logic tx_active_o,
  output logic tx_serial_o,
  output logic rx_valid_o,
  output logic [10:0] rx_word_o,
  input wire logic rx_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  xcv_tx_word_type last_q;
  logic [3:0] busy_q;
  logic [3:0] n_tx_q;
  assign tx_ready_o = !stall_i;
  assign tx_active_o = busy_q != 4'h0;
  initial begin
    rx_valid_o = 1'b0;
    rx_word_o = 11'h000;
  end
  // each accepted word keeps the line busy for eight cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 4'h0;
      n_tx_q <= 4'h0;
      last_q <= '0;
      tx_serial_o <= 1'b0;
    end else begin
      tx_serial_o <= tx_active_o ? !tx_serial_o : 1'b0;
      if (tx_valid_i && tx_ready_o) begin
        busy_q <= 4'h8;
        last_q <= tx_word_i;
        n_tx_q <= n_tx_q + 4'h1;
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
      end
    end
  end
  // holds the word until ready is seen at an edge, then scrambles it
  task automatic send_rx(input logic [10:0] w);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_word_o = w;
    while (!rx_ready_i) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_word_o = ~w;
  endtask : send_rx
endmodule : xcv_far_model
`default_nettype wire

// >>> verif/xcv_regs_bench.sv
// self-checking bench for the transceiver register bank
`default_nettype none
module xcv_regs_bench
  import xcv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, pwr_n = 0, wr = 0, rd = 0, transceiver_clock_en = 0, rx_pin = 0, stall = 1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  xcv_tx_word_type tx_word;
  xcv_rx_event_type rx_ev = '0;
  logic tx_valid, tx_ready, tx_active, tx_serial, tx_data, tx_data_n, tx_active_output, rx_serial;
  logic rx_valid, rx_ready, rx_abort, xr, line_act;
  logic [10:0] rx_word;
  logic [2:0] proto;
  logic [1:0] tc = 2'h0;
  int n_errors = 0, checks = 0, cycles = 0, aborts = 0;

  xcv_regs xcv_regs_inst (.CLOCK_I(clk), .RESETN_I(rst_n), .PWR_RESETN_I(pwr_n),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdata),
    .TRANSCEIVER_CLOCK_EN_I(transceiver_clock_en), .TX_WORD_O(tx_word), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
    .TX_ACTIVE_I(tx_active), .TX_SERIAL_I(tx_serial), .TX_DATA_O(tx_data),
    .TX_DATA_N_O(tx_data_n), .TX_ACTIVE_OUTPUT_O(tx_active_output), .RX_PIN_I(rx_pin), .RX_SERIAL_O(rx_serial),
    .RX_WORD_I(rx_word), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .RX_EVENT_I(rx_ev),
    .RX_ABORT_O(rx_abort), .XCVR_RESET_O(xr), .PROTOCOL_O(proto), .LINE_ACTIVE_O(line_act));
  xcv_far_model far_inst (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .tx_valid_i(tx_valid),
    .tx_word_i(tx_word), .tx_ready_o(tx_ready), .tx_active_o(tx_active),
    .tx_serial_o(tx_serial), .rx_valid_o(rx_valid), .rx_word_o(rx_word), .rx_ready_i(rx_ready));

  always #20 clk = !clk;
  // one transceiver clock enable every fourth cycle
  always @(posedge clk) begin
    tc <= tc + 2'h1;
    transceiver_clock_en <= #1 (tc == 2'h3);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      complete_run();
    end
  end
  // the abort strobe lasts one cycle, so it is counted rather than sampled
  always @(posedge clk) begin
    if (rx_abort === 1'b1) aborts++;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask : wreg
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(12'(rdata & m), 12'(exp));
  endtask : rc
  task automatic ev(input xcv_rx_event_type e);
    cyc(1);
    rx_ev = e;
    cyc(1);
    rx_ev = '0;
  endtask : ev
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial begin
    cyc(4);
    rst_n = 1'b1;
    pwr_n = 1'b1;
    rc(IDX_MODE, 8'hff, MODE_RESET_VAL);
    rc(IDX_COMMAND, 8'hff, CMD_RESET_VAL);
    rc(IDX_STATUS, 8'hff, 8'h00);
    rc(3'h1, 8'hff, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wreg(IDX_MODE, 8'(i));
      rc(IDX_MODE, 8'hff, 8'(i));
      chk(12'(proto), 12'(i));
    end
    wreg(IDX_MODE, 8'h00);
    endt("modes");
    // fill the transmit fifo; no further write while full reads high
    wreg(IDX_COMMAND, 8'h0d);
    for (int i = 0; i < TX_FIFO_DEPTH; i++) wreg(IDX_FIFO_PORT, 8'ha0 + 8'(i));
    chk(12'(tx_word), {1'b1, 3'h5, 8'ha0});
    rc(IDX_STATUS, 8'hff, 8'h80);
    stall = 1'b0;
    cyc(2);
    chk(12'(tx_active_output), 12'h1);
    rc(IDX_STATUS, 8'hc0, 8'h40);
    cyc(20);
    chk(12'(far_inst.n_tx_q), 12'(TX_FIFO_DEPTH));
    chk(12'(far_inst.last_q), {1'b1, 3'h5, 8'ha1});
    wreg(IDX_MODE, 8'h08);
    cyc(2);
    chk(12'({tx_data, tx_data_n}), 12'h2);
    wreg(IDX_MODE, 8'h50);
    wreg(IDX_FIFO_PORT, 8'h11);
    cyc(3);
    chk(12'(rx_serial), 12'(!tx_serial));
    chk(12'(tx_active_output), 12'h0);
    rc(IDX_STATUS, 8'h40, 8'h40);
    wreg(IDX_MODE, 8'h00);
    cyc(10);
    chk(12'({tx_data, tx_data_n}), 12'h1);
    endt("transmit");
    for (int i = 0; i < RX_FIFO_DEPTH; i++) far_inst.send_rx(11'h5a0 + 11'(i));
    chk(12'(rx_ready), 12'h0);
    rc(IDX_STATUS, 8'h0f, 8'h0d);
    for (int i = 0; i < RX_FIFO_DEPTH; i++) rc(IDX_FIFO_PORT, 8'hff, 8'ha0 + 8'(i));
    rc(IDX_STATUS, 8'h08, 8'h00);
    far_inst.send_rx(11'h3c3);
    ev(6'h20);
    rc(IDX_STATUS, 8'h1f, 8'h1b);
    ev(6'h04);
    rc(IDX_STATUS, 8'h3f, 8'h23);
    wreg(IDX_COMMAND, 8'h40);
    rc(IDX_FIFO_PORT, 8'hff, 8'h08);
    rc(IDX_STATUS, 8'h20, 8'h00);
    wreg(IDX_COMMAND, 8'h00);
    rc(IDX_FIFO_PORT, 8'hff, 8'hc3);
    ev(6'h20);
    ev(6'h10);
    rc(IDX_STATUS, 8'h10, 8'h00);
    endt("receive");
    // transmit start while receiving, without and with concurrent receive
    ev(6'h20);
    wreg(IDX_FIFO_PORT, 8'h22);
    cyc(3);
    rc(IDX_STATUS, 8'h10, 8'h00);
    chk(12'(aborts), 12'h1);
    wreg(IDX_COMMAND, 8'h40);
    rc(IDX_FIFO_PORT, 8'h01, 8'h01);
    wreg(IDX_COMMAND, 8'h00);
    wreg(IDX_MODE, 8'h20);
    ev(6'h20);
    wreg(IDX_FIFO_PORT, 8'h33);
    cyc(3);
    rc(IDX_STATUS, 8'h10, 8'h10);
    chk(12'(aborts), 12'h1);
    ev(6'h10);
    wreg(IDX_MODE, 8'h00);
    endt("concurrent");
    // two-byte address framing: receiver active drops with line activity
    wreg(IDX_MODE, 8'h04);
    ev(6'h20);
    rx_pin = 1'b1;
    cyc(5);
    chk(12'(line_act), 12'h1);
    repeat (13) @(posedge transceiver_clock_en);
    cyc(1);
    chk(12'(line_act), 12'h1);
    rc(IDX_STATUS, 8'h10, 8'h10);
    repeat (4) @(posedge transceiver_clock_en);
    cyc(2);
    chk(12'(line_act), 12'h0);
    rc(IDX_STATUS, 8'h10, 8'h00);
    endt("activity");
    stall = 1'b1;
    wreg(IDX_FIFO_PORT, 8'h44);
    far_inst.send_rx(11'h155);
    wreg(IDX_MODE, 8'h80);
    cyc(2);
    chk(12'({xr, tx_valid}), 12'h2);
    rc(IDX_STATUS, 8'hff, 8'h00);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    rc(IDX_MODE, 8'hff, 8'h80);
    chk(12'(xr), 12'h1);
    endt("reset bit");
    complete_run();
  end
endmodule : xcv_regs_bench
`default_nettype wire
